// >>> hw/afrx_pkg.sv
// constants, register map and timing for the strobe-driven buffer controller
package afrx_pkg;

  // ==========================================================
  // clock and timing figures
  localparam int CLK_MHZ = 250;
  localparam int T_PW_NS = 20;  // write strobe low time
  localparam int T_WR_NS = 10;  // write strobe recovery
  localparam int T_PR_NS = 20;  // read strobe low time
  localparam int T_RR_NS = 10;  // read strobe recovery
  localparam int T_SD_NS = 12;  // data setup before write rises
  localparam int T_PMR_NS = 20; // master reset low time
  localparam int T_RMR_NS = 10; // master reset recovery
  localparam int T_PRT_NS = 20; // replay low time
  localparam int T_RTR_NS = 10; // replay recovery
  localparam int T_FLAG_NS = 20; // longest strobe to flag delay

  // least time in ns to whole cycles, never below one
  function automatic int afrx_cyc(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction : afrx_cyc

  function automatic int afrx_max(input int a, input int b);
    return (a > b) ? a : b;
  endfunction : afrx_max

  localparam int PW_CYC = afrx_max(afrx_cyc(T_PW_NS), afrx_cyc(T_SD_NS));
  localparam int PR_CYC = afrx_cyc(T_PR_NS);
  localparam int PMR_CYC = afrx_cyc(T_PMR_NS);
  localparam int PRT_CYC = afrx_cyc(T_PRT_NS);
  // recoveries also wait until the flags have settled
  localparam int WR_CYC = afrx_max(afrx_cyc(T_WR_NS), afrx_cyc(T_FLAG_NS));
  localparam int RR_CYC = afrx_max(afrx_cyc(T_RR_NS), afrx_cyc(T_FLAG_NS));
  localparam int RMR_CYC = afrx_max(afrx_cyc(T_RMR_NS), afrx_cyc(T_FLAG_NS));
  localparam int RTR_CYC = afrx_max(afrx_cyc(T_RTR_NS), afrx_cyc(T_FLAG_NS));

  // ==========================================================
  // device geometry
  localparam int DEV_WORDS = 512;
  localparam int DEV_BITS = 9;

  // ==========================================================
  // register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_WCOUNT = 8'h14;
  localparam int CTRL_DEPTH = 0;
  localparam int CMD_RESET = 0;
  localparam int CMD_REPLAY = 1;
  localparam int CMD_READ = 2;
  localparam int ST_BUSY = 0;
  localparam int ST_EMPTY_N = 1;
  localparam int ST_FULL_N = 2;
  localparam int ST_HALF_N = 3;
  localparam int ST_RVALID = 4;
  localparam int ST_REFUSED = 5;
  localparam int ST_RESET_OK = 6;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // address decode shared by both bus directions
  function automatic logic afrx_hit(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= REG_WCOUNT);
  endfunction : afrx_hit

  // byte enables to a bit mask
  function automatic logic [31:0] afrx_mask(input logic [3:0] s);
    return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction : afrx_mask

endpackage : afrx_pkg

// >>> hw/afrx_reg_if.sv
// register access carrier between the bus slave and the controller core
`timescale 1ns/1ps
interface afrx_reg_if;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;

  modport bus (output wr_en, output wr_addr, output wr_data, output wr_strb, output rd_addr, input rd_data);
  modport core (input wr_en, input wr_addr, input wr_data, input wr_strb, input rd_addr, output rd_data);
endinterface : afrx_reg_if

// >>> hw/afrx_timer.sv
// down counter that marks the last cycle of a timed pin phase
`timescale 1ns/1ps
module afrx_timer (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // control
  input wire logic start,
  input wire logic [7:0] load,
  // last cycle of the phase
  output logic done
);

  logic [7:0] count_q;

  // ==========================================================
  // count down from the loaded length
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      count_q <= 8'h00;
    else if (start)
      count_q <= load;
    else if (count_q != 8'h00)
      count_q <= count_q - 8'h01;
  end

  assign done = (count_q == 8'h01);

endmodule : afrx_timer

// >>> hw/afrx_axil.sv
// axi4-lite slave front end for the controller registers
`timescale 1ns/1ps
module afrx_axil (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // write address and data
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [7:0] s_awaddr,
  input wire logic s_wvalid,
  output logic s_wready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  // write response
  output logic s_bvalid,
  input wire logic s_bready,
  output logic [1:0] s_bresp,
  // read address and data
  input wire logic s_arvalid,
  output logic s_arready,
  input wire logic [7:0] s_araddr,
  output logic s_rvalid,
  input wire logic s_rready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  // register side
  afrx_reg_if.bus regs
);

  logic aw_have_q;
  logic w_have_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic fire;

  assign s_awready = !aw_have_q && !s_bvalid;
  assign s_wready = !w_have_q && !s_bvalid;
  assign fire = aw_have_q && w_have_q && !s_bvalid;
  assign s_arready = !s_rvalid;

  // ==========================================================
  // write channel capture, either order
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end
    else
    begin
      if (s_awvalid && s_awready)
      begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_awaddr;
      end
      else if (fire)
        aw_have_q <= 1'b0;
      if (s_wvalid && s_wready)
      begin
        w_have_q <= 1'b1;
        wdata_q <= s_wdata;
        wstrb_q <= s_wstrb;
      end
      else if (fire)
        w_have_q <= 1'b0;
    end
  end

  // write response
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_bvalid <= 1'b0;
      s_bresp <= afrx_pkg::RESP_OKAY;
    end
    else if (fire)
    begin
      s_bvalid <= 1'b1;
      s_bresp <= afrx_pkg::afrx_hit(awaddr_q) ? afrx_pkg::RESP_OKAY : afrx_pkg::RESP_SLVERR;
    end
    else if (s_bready)
      s_bvalid <= 1'b0;
  end

  assign regs.wr_en = fire && afrx_pkg::afrx_hit(awaddr_q);
  assign regs.wr_addr = awaddr_q;
  assign regs.wr_data = wdata_q;
  assign regs.wr_strb = wstrb_q;
  assign regs.rd_addr = s_araddr;

  // ==========================================================
  // read channel, answer one cycle after the address
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_rvalid <= 1'b0;
      s_rdata <= 32'h00000000;
      s_rresp <= afrx_pkg::RESP_OKAY;
    end
    else if (s_arvalid && s_arready)
    begin
      s_rvalid <= 1'b1;
      s_rdata <= afrx_pkg::afrx_hit(s_araddr) ? regs.rd_data : 32'h00000000;
      s_rresp <= afrx_pkg::afrx_hit(s_araddr) ? afrx_pkg::RESP_OKAY : afrx_pkg::RESP_SLVERR;
    end
    else if (s_rready)
      s_rvalid <= 1'b0;
  end

endmodule : afrx_axil

// >>> hw/afrx_ctrl.sv
// controller that drives a chain of strobe-timed first-in first-out buffers
`timescale 1ns/1ps
module afrx_ctrl #(
  parameter int LANES = 1,
  parameter int DEPTH = afrx_pkg::DEV_WORDS
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // axi4-lite write address and data
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [7:0] s_awaddr,
  input wire logic s_wvalid,
  output logic s_wready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  // axi4-lite write response
  output logic s_bvalid,
  input wire logic s_bready,
  output logic [1:0] s_bresp,
  // axi4-lite read
  input wire logic s_arvalid,
  output logic s_arready,
  input wire logic [7:0] s_araddr,
  output logic s_rvalid,
  input wire logic s_rready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  // strobes shared by all devices
  output logic write_n,
  output logic read_n,
  output logic replay_n,
  output logic master_reset_n,
  // data to and from the devices
  output logic [LANES*afrx_pkg::DEV_BITS-1:0] write_data_in,
  input wire logic [LANES*afrx_pkg::DEV_BITS-1:0] read_data_out,
  // per-device flags
  input wire logic [LANES-1:0] empty_flag_n,
  input wire logic [LANES-1:0] full_flag_n,
  input wire logic [LANES-1:0] half_full_flag_n,
  // mode straps
  output logic [LANES-1:0] first_load_strap_n,
  output logic [LANES-1:0] chain_in_n,
  output logic chain_in_oe
);

  localparam int DW = LANES * afrx_pkg::DEV_BITS;
  localparam logic [15:0] WCOUNT_CAP = 16'(DEPTH + 1);

  typedef enum {
    AFRX_IDLE, AFRX_WR_PULSE, AFRX_WR_REC, AFRX_RD_PULSE, AFRX_RD_REC,
    AFRX_MR_PULSE, AFRX_MR_REC, AFRX_RT_PULSE, AFRX_RT_REC
  } afrx_state_type;

  afrx_reg_if regs ();

  afrx_state_type state_q;
  afrx_state_type state_d;
  logic tmr_start;
  logic [7:0] tmr_load;
  logic tmr_done;
  logic depth_q;
  logic boot_q;
  logic [DW-1:0] wdata_q;
  logic [DW-1:0] rdata_q;
  logic rvalid_q;
  logic refused_q;
  logic refuse;
  logic reset_ok_q;
  logic [15:0] wcount_q;
  logic [31:0] wmask;
  logic [31:0] wbits;
  logic c_rst;
  logic c_rt;
  logic c_rd;
  logic c_wr;
  logic c_ctrl;
  logic c_clr;
  logic any_cmd;
  logic comp_empty_n;
  logic comp_full_n;
  logic comp_half_n;

  // ==========================================================
  // bus slave and phase timer
  afrx_axil u_axil (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .s_awvalid(s_awvalid),
    .s_awready(s_awready),
    .s_awaddr(s_awaddr),
    .s_wvalid(s_wvalid),
    .s_wready(s_wready),
    .s_wdata(s_wdata),
    .s_wstrb(s_wstrb),
    .s_bvalid(s_bvalid),
    .s_bready(s_bready),
    .s_bresp(s_bresp),
    .s_arvalid(s_arvalid),
    .s_arready(s_arready),
    .s_araddr(s_araddr),
    .s_rvalid(s_rvalid),
    .s_rready(s_rready),
    .s_rdata(s_rdata),
    .s_rresp(s_rresp),
    .regs(regs.bus)
  );

  afrx_timer u_timer (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .start(tmr_start),
    .load(tmr_load),
    .done(tmr_done)
  );

  // ==========================================================
  // composite flags: lane 0 in width mode; in depth mode empty and full are the or of all, half-full held high
  assign comp_empty_n = depth_q ? |empty_flag_n : empty_flag_n[0];
  assign comp_full_n = depth_q ? |full_flag_n : full_flag_n[0];
  assign comp_half_n = depth_q ? 1'b1 : half_full_flag_n[0];

  // straps: one first-load device in depth mode, chain input grounded otherwise
  generate
    for (genvar i = 0; i < LANES; i++)
    begin : g_strap
      assign first_load_strap_n[i] = !(depth_q && (i == 0));
      assign chain_in_n[i] = 1'b0;
    end
  endgenerate
  assign chain_in_oe = !depth_q;

  // ==========================================================
  // register write decode
  assign wmask = afrx_pkg::afrx_mask(regs.wr_strb);
  assign wbits = regs.wr_data & wmask;
  assign c_ctrl = regs.wr_en && (regs.wr_addr == afrx_pkg::REG_CTRL);
  assign c_rst = regs.wr_en && (regs.wr_addr == afrx_pkg::REG_CMD) && wbits[afrx_pkg::CMD_RESET];
  assign c_rt = regs.wr_en && (regs.wr_addr == afrx_pkg::REG_CMD) && wbits[afrx_pkg::CMD_REPLAY];
  assign c_rd = regs.wr_en && (regs.wr_addr == afrx_pkg::REG_CMD) && wbits[afrx_pkg::CMD_READ];
  assign c_wr = regs.wr_en && (regs.wr_addr == afrx_pkg::REG_WDATA);
  assign c_clr = regs.wr_en && (regs.wr_addr == afrx_pkg::REG_STATUS) && wbits[afrx_pkg::ST_REFUSED];
  assign any_cmd = c_rst || c_rt || c_rd || c_wr;

  // ==========================================================
  // sequencer: choose next phase and its length
  always_comb
  begin
    state_d = state_q;
    tmr_start = 1'b0;
    tmr_load = 8'h00;
    refuse = 1'b0;
    case (state_q)
      AFRX_IDLE:
      begin
        if (boot_q || c_rst)
        begin
          state_d = AFRX_MR_PULSE;
          tmr_start = 1'b1;
          tmr_load = 8'(afrx_pkg::PMR_CYC);
        end
        else if (c_rt)
        begin
          // refused in a chain or once more words went in than fit
          if (depth_q || (wcount_q > 16'(DEPTH)))
            refuse = 1'b1;
          else
          begin
            state_d = AFRX_RT_PULSE;
            tmr_start = 1'b1;
            tmr_load = 8'(afrx_pkg::PRT_CYC);
          end
        end
        else if (c_rd)
        begin
          if (!comp_empty_n)
            refuse = 1'b1;
          else
          begin
            state_d = AFRX_RD_PULSE;
            tmr_start = 1'b1;
            tmr_load = 8'(afrx_pkg::PR_CYC);
          end
        end
        else if (c_wr)
        begin
          if (!comp_full_n)
            refuse = 1'b1;
          else
          begin
            state_d = AFRX_WR_PULSE;
            tmr_start = 1'b1;
            tmr_load = 8'(afrx_pkg::PW_CYC);
          end
        end
      end
      AFRX_WR_PULSE:
      if (tmr_done)
      begin
        state_d = AFRX_WR_REC;
        tmr_start = 1'b1;
        tmr_load = 8'(afrx_pkg::WR_CYC);
      end
      AFRX_RD_PULSE:
      if (tmr_done)
      begin
        state_d = AFRX_RD_REC;
        tmr_start = 1'b1;
        tmr_load = 8'(afrx_pkg::RR_CYC);
      end
      AFRX_MR_PULSE:
      if (tmr_done)
      begin
        state_d = AFRX_MR_REC;
        tmr_start = 1'b1;
        tmr_load = 8'(afrx_pkg::RMR_CYC);
      end
      AFRX_RT_PULSE:
      if (tmr_done)
      begin
        state_d = AFRX_RT_REC;
        tmr_start = 1'b1;
        tmr_load = 8'(afrx_pkg::RTR_CYC);
      end
      AFRX_WR_REC, AFRX_RD_REC, AFRX_MR_REC, AFRX_RT_REC:
      if (tmr_done)
        state_d = AFRX_IDLE;
      default:
        state_d = AFRX_IDLE;
    endcase
    // commands arriving mid-sequence are refused
    if ((state_q != AFRX_IDLE) && any_cmd)
      refuse = 1'b1;
  end

  // state register
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      state_q <= AFRX_IDLE;
    else
      state_q <= state_d;
  end

  // power-up master reset request
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      boot_q <= 1'b1;
    else if (state_d == AFRX_MR_PULSE)
      boot_q <= 1'b0;
  end

  // ==========================================================
  // pin strobes, registered from the next phase
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      write_n <= 1'b1;
      read_n <= 1'b1;
      replay_n <= 1'b1;
      master_reset_n <= 1'b1;
    end
    else
    begin
      // one strobe set for every device of a width group
      write_n <= (state_d != AFRX_WR_PULSE);
      read_n <= (state_d != AFRX_RD_PULSE);
      // strobes stay high through replay pulse and recovery
      replay_n <= (state_d != AFRX_RT_PULSE);
      master_reset_n <= (state_d != AFRX_MR_PULSE);
    end
  end

  // write data, loaded on the same edge the strobe falls and held until after it rises
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      wdata_q <= '0;
    else if ((state_q == AFRX_IDLE) && c_wr && !boot_q && !c_rst && !c_rt && !c_rd)
      wdata_q <= wbits[DW-1:0];
  end
  assign write_data_in = wdata_q;

  // ==========================================================
  // read capture at the last cycle before the read strobe rises
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rdata_q <= '0;
      rvalid_q <= 1'b0;
    end
    else if ((state_q == AFRX_RD_PULSE) && tmr_done)
    begin
      rdata_q <= read_data_out;
      rvalid_q <= 1'b1;
    end
    else if (state_d == AFRX_MR_PULSE)
      rvalid_q <= 1'b0;
  end

  // writes since the last master reset, saturating just above the depth
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      wcount_q <= 16'h0000;
    else if (state_d == AFRX_MR_PULSE)
      wcount_q <= 16'h0000;
    else if ((state_q == AFRX_IDLE) && (state_d == AFRX_WR_PULSE) && (wcount_q < WCOUNT_CAP))
      wcount_q <= wcount_q + 16'h0001;
  end

  // refused command, sticky, set wins over clear
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      refused_q <= 1'b0;
    else
      refused_q <= (refused_q && !c_clr) || refuse;
  end

  // master reset outcome checked once flags have settled
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      reset_ok_q <= 1'b0;
    else if (state_d == AFRX_MR_PULSE)
      reset_ok_q <= 1'b0;
    else if ((state_q == AFRX_MR_REC) && tmr_done)
      reset_ok_q <= !comp_empty_n && comp_full_n && comp_half_n;
  end

  // ==========================================================
  // control register
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      depth_q <= 1'b0;
    else if (c_ctrl)
      depth_q <= (depth_q && !wmask[afrx_pkg::CTRL_DEPTH]) || wbits[afrx_pkg::CTRL_DEPTH];
  end

  // register read mux
  always_comb
  begin
    regs.rd_data = 32'h00000000;
    case (regs.rd_addr)
      afrx_pkg::REG_CTRL:
        regs.rd_data[afrx_pkg::CTRL_DEPTH] = depth_q;
      afrx_pkg::REG_WDATA:
        regs.rd_data[DW-1:0] = wdata_q;
      afrx_pkg::REG_RDATA:
        regs.rd_data[DW-1:0] = rdata_q;
      afrx_pkg::REG_STATUS:
      begin
        regs.rd_data[afrx_pkg::ST_BUSY] = (state_q != AFRX_IDLE) || boot_q;
        regs.rd_data[afrx_pkg::ST_EMPTY_N] = comp_empty_n;
        regs.rd_data[afrx_pkg::ST_FULL_N] = comp_full_n;
        regs.rd_data[afrx_pkg::ST_HALF_N] = comp_half_n;
        regs.rd_data[afrx_pkg::ST_RVALID] = rvalid_q;
        regs.rd_data[afrx_pkg::ST_REFUSED] = refused_q;
        regs.rd_data[afrx_pkg::ST_RESET_OK] = reset_ok_q;
      end
      afrx_pkg::REG_WCOUNT:
        regs.rd_data[15:0] = wcount_q;
      default:
        regs.rd_data = 32'h00000000;
    endcase
  end

endmodule : afrx_ctrl

// >>> test/afrx_ctrl_monitor.sv
// checker on the controller pins
`timescale 1ns/1ps
module afrx_ctrl_monitor #(
  parameter int LANES = 1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // strobes
  input wire logic write_n,
  input wire logic read_n,
  input wire logic replay_n,
  input wire logic master_reset_n,
  // flags and straps
  input wire logic [LANES-1:0] empty_flag_n,
  input wire logic [LANES-1:0] full_flag_n,
  input wire logic [LANES-1:0] first_load_strap_n,
  input wire logic [LANES-1:0] chain_in_n,
  input wire logic chain_in_oe
);
  // ==========
  // pin checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  rd_guard_a: assert property ($fell(read_n) |-> $past(empty_flag_n[0])) else $error("read on empty");
  wr_guard_a: assert property ($fell(write_n) |-> $past(full_flag_n[0])) else $error("write on full");
  rd_pulse_a: assert property ($fell(read_n) |-> (!read_n && write_n)[*5] ##1 read_n[*5])
    else $error("read pulse shape");
  replay_quiet_a: assert property ($fell(replay_n) |-> (!replay_n && read_n && write_n)[*5]
    ##1 (replay_n && read_n && write_n)[*5]) else $error("strobe during replay");
  replay_mode_a: assert property ($fell(replay_n) |-> chain_in_oe) else $error("replay in chain");
  mr_quiet_a: assert property (!master_reset_n |-> read_n && write_n && replay_n)
    else $error("strobe during reset");
  strap_alone_a: assert property (chain_in_oe |-> &first_load_strap_n) else $error("strap alone");
  chain_ground_a: assert property (chain_in_oe |-> (chain_in_n == '0)) else $error("chain input not low");
  strap_depth_a: assert property (!chain_in_oe |-> !first_load_strap_n[0]) else $error("strap depth");
endmodule : afrx_ctrl_monitor

bind afrx_ctrl afrx_ctrl_monitor #(.LANES(LANES)) u_mon (.ref_clk(ref_clk), .resetn(resetn),
  .write_n(write_n), .read_n(read_n), .replay_n(replay_n), .master_reset_n(master_reset_n),
  .empty_flag_n(empty_flag_n), .full_flag_n(full_flag_n), .first_load_strap_n(first_load_strap_n),
  .chain_in_n(chain_in_n), .chain_in_oe(chain_in_oe));

// >>> test/afrx_fifo_model.sv
// behavioural model of one strobe-timed buffer device
`timescale 1ns/1ps
module afrx_fifo_model (
  // strobes
  input wire logic write_n,
  input wire logic read_n,
  input wire logic replay_n,
  input wire logic master_reset_n,
  // data and flags
  input wire logic [8:0] write_data_in,
  output logic [8:0] read_data_out,
  output logic empty_flag_n,
  output logic full_flag_n,
  output logic half_full_flag_n,
  // chain link
  output logic chain_out_n
);
  logic [8:0] mem [512];
  logic [8:0] q = 9'h000;
  logic drv = 1'b0;
  int wp = 0;
  int rp = 0;
  int cnt = 0;
  logic xo_n = 1'b1;
  // chain output pulses low on the last location
  assign chain_out_n = xo_n;
  // flags from pointer distance
  assign empty_flag_n = (cnt != 0);
  assign full_flag_n = (cnt != 512);
  assign half_full_flag_n = (cnt <= 256);
  // floating outputs show the inverted word
  assign read_data_out = drv ? q : ~q;
  // master reset empties
  always @(negedge master_reset_n)
  begin
    wp = 0;
    rp = 0;
    cnt = 0;
  end
  // replay from first location
  always @(negedge replay_n)
  begin
    rp = 0;
    cnt = wp;
  end
  // store at rising strobe unless full
  always @(posedge write_n)
  begin
    if (cnt < 512)
    begin
      mem[wp % 512] = write_data_in;
      wp = wp + 1;
      cnt = cnt + 1;
      if ((wp % 512) == 0)
      begin
        xo_n = 1'b0;
        xo_n <= #4 1'b1;
      end
    end
  end
  // fetch at falling strobe unless empty
  always @(negedge read_n)
  begin
    if (cnt > 0)
    begin
      q = mem[rp % 512];
      rp = rp + 1;
      cnt = cnt - 1;
      drv = 1'b1;
      if ((rp % 512) == 0)
      begin
        xo_n = 1'b0;
        xo_n <= #4 1'b1;
      end
    end
  end
  // float again when strobe rises
  always @(posedge read_n) drv = 1'b0;
endmodule : afrx_fifo_model

// >>> test/afrx_ctrl_tb_top.sv
// self-checking bench for the buffer controller
`timescale 1ns/1ps
module afrx_ctrl_tb_top;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic s_awvalid = 1'b0;
  logic s_wvalid = 1'b0;
  logic s_bready = 1'b0;
  logic s_arvalid = 1'b0;
  logic s_rready = 1'b0;
  logic [7:0] s_awaddr = 8'h00;
  logic [7:0] s_araddr = 8'h00;
  logic [31:0] s_wdata = 32'h0;
  logic [3:0] s_wstrb = 4'hF;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0] s_bresp, s_rresp;
  logic [31:0] s_rdata;
  logic wr_n, rd_n, rt_n, mr_n, ef, ff, hf, oe;
  logic [8:0] wd, rd;
  logic [1:0] exp_b [$];
  logic [65:0] exp_r [$];
  logic [8:0] hist [$];
  logic [8:0] pend [$];
  logic [65:0] note;
  int fails = 0;
  int num_checks = 0;
  int cyc = 0;
  always #2 ref_clk = ~ref_clk;
  // ==========
  // design and device
  afrx_ctrl dut (.ref_clk(ref_clk), .resetn(resetn), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_awaddr(s_awaddr), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
    .s_bvalid(s_bvalid), .s_bready(s_bready), .s_bresp(s_bresp), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_araddr(s_araddr), .s_rvalid(s_rvalid), .s_rready(s_rready), .s_rdata(s_rdata), .s_rresp(s_rresp),
    .write_n(wr_n), .read_n(rd_n), .replay_n(rt_n), .master_reset_n(mr_n), .write_data_in(wd),
    .read_data_out(rd), .empty_flag_n(ef), .full_flag_n(ff), .half_full_flag_n(hf),
    .first_load_strap_n(), .chain_in_n(), .chain_in_oe(oe));
  afrx_fifo_model u_dev (.write_n(wr_n), .read_n(rd_n), .replay_n(rt_n), .master_reset_n(mr_n),
    .write_data_in(wd), .read_data_out(rd), .empty_flag_n(ef), .full_flag_n(ff), .half_full_flag_n(hf),
    .chain_out_n());
  // ==========
  // tasks
  task automatic check(input logic [39:0] got, input logic [39:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_b.push_back(r);
    s_awvalid <= 1'b1;
    s_awaddr <= a;
    s_wvalid <= 1'b1;
    s_wdata <= d;
    s_bready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
    end while (s_bvalid !== 1'b1);
    s_bready <= 1'b0;
    @(posedge ref_clk);
  endtask : axw
  task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, output logic [31:0] g);
    exp_r.push_back({(a > 8'h14 ? 2'h2 : 2'h0), m, e});
    s_arvalid <= 1'b1;
    s_araddr <= a;
    s_rready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (s_arready) s_arvalid <= 1'b0;
    end while (s_rvalid !== 1'b1);
    g = s_rdata;
    s_rready <= 1'b0;
    @(posedge ref_clk);
  endtask : axr
  task automatic st(input logic [31:0] e, input logic [31:0] m);
    logic [31:0] g;
    axr(8'h10, e, m, g);
  endtask : st
  task automatic idle;
    logic [31:0] g;
    int n;
    g = 32'h1;
    n = 0;
    while (g[0] !== 1'b0 && n < 40)
    begin
      axr(8'h10, 32'h0, 32'h0, g);
      n++;
    end
  endtask : idle
  task automatic cmd(input logic [7:0] a, input logic [31:0] d);
    axw(a, d, 2'h0);
    idle();
  endtask : cmd
  task automatic put(input logic [8:0] d);
    hist.push_back(d);
    pend.push_back(d);
    cmd(8'h08, {23'h0, d});
  endtask : put
  task automatic take;
    logic [31:0] g;
    cmd(8'h04, 32'h4);
    axr(8'h0C, {23'h0, pend.pop_front()}, 32'h1FF, g);
  endtask : take
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  // ==========
  // result watcher and timeout
  always @(posedge ref_clk)
  begin
    cyc++;
    if (s_bvalid === 1'b1 && s_bready && exp_b.size() > 0) check(s_bresp, exp_b.pop_front());
    if (s_rvalid === 1'b1 && s_rready && exp_r.size() > 0)
    begin
      note = exp_r.pop_front();
      check({s_rresp, s_rdata & note[63:32]}, {note[65:64], note[31:0]});
    end
    if (cyc == 40000)
    begin
      fails++;
      tally_and_finish();
    end
  end
  // ==========
  // test sequence
  initial
  begin
    logic [31:0] g;
    void'($urandom(42));
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    idle();
    st(32'h4C, 32'h7F);
    axw(8'h18, 32'h1, 2'h2);
    axr(8'h18, 32'h0, 32'hFFFFFFFF, g);
    $display("test reset done");
    cmd(8'h04, 32'h4);
    st(32'h20, 32'h22);
    cmd(8'h10, 32'h20);
    repeat (5) put($urandom);
    st(32'h02, 32'h02);
    axr(8'h14, 32'h5, 32'hFFFFFFFF, g);
    repeat (5) take();
    st(32'h10, 32'h32);
    cmd(8'h04, 32'h4);
    pend = hist;
    st(32'h20, 32'h22);
    cmd(8'h10, 32'h20);
    cmd(8'h04, 32'h2);
    st(32'h02, 32'h02);
    put($urandom);
    repeat (6) take();
    $display("test replay done");
    cmd(8'h04, 32'h1);
    hist.delete();
    pend.delete();
    for (int i = 0; i < 512; i++)
    begin
      put($urandom);
      if (i == 255) st(32'h08, 32'h08);
      if (i == 256) st(32'h00, 32'h08);
    end
    st(32'h00, 32'h04);
    cmd(8'h08, 32'h5A);
    axr(8'h08, 32'h5A, 32'h1FF, g);
    st(32'h20, 32'h24);
    cmd(8'h10, 32'h20);
    take();
    st(32'h04, 32'h04);
    put($urandom);
    axr(8'h14, 32'h201, 32'hFFFFFFFF, g);
    cmd(8'h04, 32'h2);
    st(32'h20, 32'h20);
    cmd(8'h10, 32'h20);
    $display("test full done");
    cmd(8'h00, 32'h1);
    cmd(8'h04, 32'h2);
    st(32'h28, 32'h28);
    cmd(8'h00, 32'h0);
    $display("test depth done");
    tally_and_finish();
  end
endmodule : afrx_ctrl_tb_top
